/* hw/smc_pkg.sv */
// Constants and types for the serial master/slave controller.
// Assumes one clock domain; link pins arrive unsynchronised from outside.
package smc_pkg;
	localparam int DATA_W = 9;
	localparam int DIV_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [3:0] CHAR_LEN_8 = 4'h8;
	localparam logic [3:0] CHAR_LEN_9 = 4'h9;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
	// Pin vector order in the input filter.
	localparam int PIN_SCK = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_MISO = 2;
	localparam int PIN_SS = 3;
	// Filter idle value: select high, others low.
	localparam logic [3:0] PIN_IDLE = 4'h8;
	localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;
	typedef enum logic [3:0] {
		SMC_IDLE = 4'b0001,
		SMC_SETUP = 4'b0010,
		SMC_XFER = 4'b0100,
		SMC_HOLD = 4'b1000
	} smc_state_t;
endpackage

/* hw/smc_core.sv */
// Serial master/slave controller: shifter, clock divider, holding and receive buffers.
// Assumes one 50 MHz clock and a synchronous reset; configuration inputs are steady while busy.
`timescale 1ns/10ps
module smc_core
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic master_mode,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsb_first,
	input wire logic char9,
	input wire logic [smc_pkg::DIV_W-1:0] clk_div,
	input wire logic addr_en,
	input wire logic [smc_pkg::ADDR_W-1:0] own_addr,
	input wire logic [smc_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [smc_pkg::DATA_W-1:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_overrun,
	output logic busy,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe,
	input wire logic ss_n_i,
	output logic ss_n_o,
	output logic ss_n_oe
);
	// Position of bit number idx within a character of length len.
	function automatic logic [3:0] bit_pos(input logic [3:0] idx, input logic lsb, input logic [3:0] len);
		bit_pos = lsb ? idx : 4'(len - idx - smc_pkg::BIT_ONE);
	endfunction

	smc_pkg::smc_state_t st_r, st_nxt;
	logic [3:0] s1_r, s2_r, s3_r, f_r, f_prev_r;
	logic [smc_pkg::DIV_W-1:0] div_r;
	logic sck_r, sck_oe_r, ss_n_r, ss_oe_r, dout_r, mosi_oe_r, miso_oe_r;
	logic [smc_pkg::DATA_W-1:0] hold_r, tx_sh_r, rx_sh_r, rx_head_r, rx_tail_r;
	logic hold_v_r, tx_ready_r, rx_head_v_r, rx_tail_v_r, ovr_r, busy_r;
	logic [3:0] bit_cnt_r;
	logic more_r, addr_phase_r, matched_r, sel_r;
	localparam int DATA_W = smc_pkg::DATA_W;
	wire [3:0] len = char9 ? smc_pkg::CHAR_LEN_9 : smc_pkg::CHAR_LEN_8;
	wire tick = (div_r == clk_div);
	wire m_lead = master_mode && st_r == smc_pkg::SMC_XFER && tick && sck_r == cpol;
	wire m_trail = master_mode && st_r == smc_pkg::SMC_XFER && tick && sck_r != cpol;
	wire s_sck_chg = f_r[smc_pkg::PIN_SCK] != f_prev_r[smc_pkg::PIN_SCK];
	wire s_sel = !master_mode && !f_r[smc_pkg::PIN_SS];
	wire s_lead = s_sel && sel_r && s_sck_chg && f_r[smc_pkg::PIN_SCK] != cpol;
	wire s_trail = s_sel && sel_r && s_sck_chg && f_r[smc_pkg::PIN_SCK] == cpol;
	wire s_start = s_sel && !sel_r;
	wire s_end = !master_mode && f_r[smc_pkg::PIN_SS] && sel_r;
	wire lead = m_lead || s_lead;
	wire trail = m_trail || s_trail;
	wire samp = cpha ? trail : lead;
	wire shft = cpha ? lead : trail;
	wire din = master_mode ? f_r[smc_pkg::PIN_MISO] : f_r[smc_pkg::PIN_MOSI];
	wire last_samp = samp && bit_cnt_r == 4'(len - smc_pkg::BIT_ONE);
	wire [smc_pkg::DATA_W-1:0] rx_done = rx_sh_r | (DATA_W'(din) << bit_pos(bit_cnt_r, lsb_first, len));
	wire m_start = master_mode && st_r == smc_pkg::SMC_IDLE && hold_v_r;
	wire load = m_start || s_start || last_samp;
	wire take_hold = load && hold_v_r;
	wire char_more = cpha ? (last_samp && hold_v_r) : more_r;
	wire m_stop = m_trail && (cpha ? last_samp : bit_cnt_r == smc_pkg::BIT_ZERO) && !char_more;
	wire addr_ok = rx_done[smc_pkg::ADDR_W-1:0] == own_addr;
	wire push = last_samp && !(master_mode == 1'b0 && addr_en && (addr_phase_r || !matched_r));
	wire pop = rx_head_v_r && rx_ready;

	// Three-stage pin capture; a level counts once stages two and three agree.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s1_r <= smc_pkg::PIN_IDLE;
			s2_r <= smc_pkg::PIN_IDLE;
			s3_r <= smc_pkg::PIN_IDLE;
			f_r <= smc_pkg::PIN_IDLE;
			f_prev_r <= smc_pkg::PIN_IDLE;
		end
		else
		begin
			s1_r <= {ss_n_i, miso_i, mosi_i, sck_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
			f_r <= (f_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r)); // Hold the old level while stages disagree.
			f_prev_r <= f_r;
		end
	end

	// Master sequencing: select low, clock out whole characters, select high.
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			smc_pkg::SMC_IDLE: if (m_start) st_nxt = smc_pkg::SMC_SETUP;
			smc_pkg::SMC_SETUP: if (tick) st_nxt = smc_pkg::SMC_XFER;
			smc_pkg::SMC_XFER: if (m_stop) st_nxt = smc_pkg::SMC_HOLD;
			smc_pkg::SMC_HOLD: if (tick) st_nxt = smc_pkg::SMC_IDLE;
			default: st_nxt = smc_pkg::SMC_IDLE;
		endcase
		if (!master_mode)
			st_nxt = smc_pkg::SMC_IDLE;
	end

	// Divider and master pin drivers.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_r <= smc_pkg::SMC_IDLE;
			div_r <= smc_pkg::DIV_ZERO;
			sck_r <= 1'b0;
			sck_oe_r <= 1'b0;
			ss_n_r <= 1'b1;
			ss_oe_r <= 1'b0;
			mosi_oe_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			div_r <= (tick || st_r == smc_pkg::SMC_IDLE) ? smc_pkg::DIV_ZERO : div_r + 1'b1;
			sck_r <= (st_r == smc_pkg::SMC_XFER && tick) ? !sck_r : (st_r == smc_pkg::SMC_XFER ? sck_r : cpol);
			sck_oe_r <= master_mode;
			ss_n_r <= !(st_nxt != smc_pkg::SMC_IDLE);
			ss_oe_r <= master_mode;
			mosi_oe_r <= master_mode;
		end
	end

	// Shifter: sample and shift on the configured edges, reload at character end.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			tx_sh_r <= smc_pkg::DATA_ZERO;
			rx_sh_r <= smc_pkg::DATA_ZERO;
			bit_cnt_r <= smc_pkg::BIT_ZERO;
			dout_r <= 1'b0;
			more_r <= 1'b0;
			sel_r <= 1'b0;
			addr_phase_r <= 1'b0;
			matched_r <= 1'b0;
			miso_oe_r <= 1'b0;
		end
		else
		begin
			sel_r <= s_sel;
			if (load)
				tx_sh_r <= hold_v_r ? hold_r : smc_pkg::DATA_ZERO;
			if (last_samp)
				more_r <= hold_v_r;
			if (s_start || m_start || s_end)
			begin
				bit_cnt_r <= smc_pkg::BIT_ZERO;
				rx_sh_r <= smc_pkg::DATA_ZERO;
			end
			else if (samp)
			begin
				bit_cnt_r <= last_samp ? smc_pkg::BIT_ZERO : bit_cnt_r + smc_pkg::BIT_ONE;
				rx_sh_r <= last_samp ? smc_pkg::DATA_ZERO : rx_done;
			end
			if (!cpha && (m_start || s_start))
				dout_r <= hold_r[bit_pos(smc_pkg::BIT_ZERO, lsb_first, len)];
			else if (shft)
				dout_r <= tx_sh_r[bit_pos(bit_cnt_r, lsb_first, len)];
			if (s_start)
			begin
				addr_phase_r <= addr_en;
				matched_r <= !addr_en;
			end
			else if (last_samp && addr_phase_r)
			begin
				addr_phase_r <= 1'b0;
				matched_r <= addr_ok;
			end
			miso_oe_r <= s_sel && sel_r && matched_r && !s_end;
		end
	end

	// Holding register and two-entry receive buffer.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			hold_r <= smc_pkg::DATA_ZERO;
			hold_v_r <= 1'b0;
			tx_ready_r <= 1'b0;
			rx_head_r <= smc_pkg::DATA_ZERO;
			rx_tail_r <= smc_pkg::DATA_ZERO;
			rx_head_v_r <= 1'b0;
			rx_tail_v_r <= 1'b0;
			ovr_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else
		begin
			if (tx_valid && tx_ready_r)
			begin
				hold_r <= tx_data;
				hold_v_r <= 1'b1;
			end
			else if (take_hold)
				hold_v_r <= 1'b0;
			tx_ready_r <= !(hold_v_r && !take_hold) && !(tx_valid && tx_ready_r);
			if (pop)
			begin
				rx_head_r <= rx_tail_v_r ? rx_tail_r : rx_done;
				rx_head_v_r <= rx_tail_v_r || push;
				rx_tail_r <= rx_done;
				rx_tail_v_r <= rx_tail_v_r && push;
			end
			else if (push && !rx_head_v_r)
			begin
				rx_head_r <= rx_done;
				rx_head_v_r <= 1'b1;
			end
			else if (push && !rx_tail_v_r)
			begin
				rx_tail_r <= rx_done;
				rx_tail_v_r <= 1'b1;
			end
			ovr_r <= push && !pop && rx_head_v_r && rx_tail_v_r;
			busy_r <= master_mode ? st_nxt != smc_pkg::SMC_IDLE : s_sel;
		end
	end

	assign tx_ready = tx_ready_r;
	assign rx_data = rx_head_r;
	assign rx_valid = rx_head_v_r;
	assign rx_overrun = ovr_r;
	assign busy = busy_r;
	assign sck_o = sck_r;
	assign sck_oe = sck_oe_r;
	assign mosi_o = dout_r;
	assign mosi_oe = mosi_oe_r;
	assign miso_o = dout_r;
	assign miso_oe = miso_oe_r;
	assign ss_n_o = ss_n_r;
	assign ss_n_oe = ss_oe_r;

	// Checks on the select, pin drivers, shifter, divider and buffers.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_master_select_low: assert property (st_r == smc_pkg::SMC_XFER |-> !ss_n_r) else $error("select high during master transfer");
	a_master_pins_only: assert property (!master_mode |=> !mosi_oe_r && !sck_oe_r) else $error("slave drove master pins");
	a_slave_miso_quiet: assert property (master_mode |=> !miso_oe_r) else $error("master drove miso");
	a_div_half_period: assert property (m_lead |-> $past(div_r) == clk_div - 1'b1 || clk_div == smc_pkg::DIV_ZERO) else $error("divider period wrong");
	a_bit_cnt_bound: assert property (bit_cnt_r < len) else $error("bit counter past character");
	a_rx_push_visible: assert property (push && !rx_head_v_r |=> rx_valid && rx_data == $past(rx_done)) else $error("received char lost");
	a_rx_tail_order: assert property (rx_tail_v_r |-> rx_head_v_r) else $error("tail without head");
	a_hold_ready: assert property (hold_v_r |-> !tx_ready_r) else $error("ready while holding full");
	a_addr_gate: assert property (!master_mode && addr_en && !matched_r |=> !miso_oe_r) else $error("unmatched slave drove");
	a_sck_idle: assert property (master_mode && st_r == smc_pkg::SMC_IDLE |=> sck_r == $past(cpol)) else $error("clock idle level wrong");
	a_char_sync: assert property (last_samp |=> bit_cnt_r == smc_pkg::BIT_ZERO) else $error("character boundary missed");
	a_stop_ends_select: assert property (st_r == smc_pkg::SMC_HOLD && tick |=> ss_n_r) else $error("select not released");
	c_master_char: cover property (master_mode && last_samp);
	c_slave_char: cover property (!master_mode && push);
	c_rx_full: cover property (rx_head_v_r && rx_tail_v_r);
	c_addr_miss: cover property (!master_mode && addr_en && last_samp && addr_phase_r && !addr_ok);
endmodule

/* sim/smc_peer.sv */
// Behavioural peripheral at the far end of the serial link, acting as slave.
// Assumes idle-low clock, leading-edge sampling and a pull-up on select.
`timescale 1ns/10ps
module smc_peer
(
	input wire logic sck,
	input wire logic mosi,
	input wire logic ss_n,
	input wire logic lsb_first,
	input wire logic char9,
	input wire logic [8:0] resp,
	output logic miso,
	output logic [8:0] got,
	output int n_chars,
	output int n_ss
);
	int idx = 0;
	int kk = 0;
	logic opened = 1'b0;
	logic [8:0] sh = 9'h000;
	logic [8:0] cur;
	// Wire position of a bit for the chosen order and length.
	function automatic int pos(input int i);
		return lsb_first ? i : (char9 ? 8 : 7) - i;
	endfunction
	initial
	begin
		miso = 1'b0;
		got = 9'h000;
		n_chars = 0;
		n_ss = 0;
	end
	// Select falling opens a transaction and shows the first reply bit.
	always @(negedge ss_n)
	begin
		idx = 0;
		kk = 0;
		opened = 1'b1;
		sh = 9'h000;
		miso = resp[pos(0)];
	end
	// Select rising closes it; the released line then no longer holds its value.
	always @(posedge ss_n)
	begin
		if (opened)
			n_ss++;
		opened = 1'b0;
		miso = ~miso;
	end
	// Sample on the rising edge; each character's reply differs in bit 0.
	always @(posedge sck)
		if (!ss_n)
		begin
			sh[pos(idx)] = mosi;
			idx++;
			if (idx == (char9 ? 9 : 8))
			begin
				got = sh;
				sh = 9'h000;
				idx = 0;
				kk++;
				n_chars++;
			end
		end
	// Shift the next reply bit on the falling edge.
	always @(negedge sck)
		if (!ss_n)
		begin
			cur = resp ^ 9'(kk[0]);
			miso = cur[pos(idx)];
		end
endmodule

/* sim/smc_core_bench.sv */
// Self-checking bench: the controller as master against the peripheral model.
// Assumes smc_peer is compiled; mode 0 with every length and bit order.
`timescale 1ns/10ps
module smc_core_bench;
	localparam int LIMIT = 40000;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic lsb_first = 1'b0;
	logic char9 = 1'b0;
	logic [smc_pkg::DIV_W-1:0] clk_div = 8'h03;
	logic [8:0] tx_data = 9'h000;
	logic tx_valid = 1'b0;
	logic rx_ready = 1'b0;
	logic [8:0] resp = 9'h000;
	logic [8:0] mask = 9'h0ff;
	logic tx_ready, rx_valid, rx_overrun, busy, peer_miso;
	logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
	logic [8:0] rx_data;
	logic [8:0] peer_got;
	int n_peer, n_ss;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int hi_run = 0;
	logic [8:0] q_rx[$];
	logic [8:0] q_peer[$];
	// Wire levels: select pulled up, clock idles low.
	wire sck_w = sck_oe ? sck_o : 1'b0;
	wire mosi_w = mosi_oe ? mosi_o : 1'b0;
	wire miso_w = miso_oe ? miso_o : peer_miso;
	wire ss_w = ss_n_oe ? ss_n_o : 1'b1;
	always #10 ref_clk = ~ref_clk;
	smc_core smc_core_inst (.ref_clk(ref_clk), .rst(rst), .master_mode(1'b1), .cpol(1'b0), .cpha(1'b0),
		.lsb_first(lsb_first), .char9(char9), .clk_div(clk_div), .addr_en(1'b0), .own_addr(8'h00),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_overrun(rx_overrun), .busy(busy), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
		.miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
	smc_peer smc_peer_inst (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .lsb_first(lsb_first), .char9(char9),
		.resp(resp), .miso(peer_miso), .got(peer_got), .n_chars(n_peer), .n_ss(n_ss));
	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Load one character and note what both ends should receive.
	task automatic send(input logic [8:0] d, input int k);
		int t;
		t = 0;
		while (tx_ready !== 1'b1 && t < 3000)
		begin
			@(negedge ref_clk);
			t++;
		end
		tx_data = d;
		tx_valid = 1'b1;
		q_peer.push_back(d & mask);
		q_rx.push_back((resp ^ 9'(k)) & mask);
		@(negedge ref_clk);
		tx_valid = 1'b0;
		check("tx_ready", {8'h00, tx_ready}, 9'h000);
	endtask
	task automatic wait_idle(input int tgt);
		int t;
		t = 0;
		while (!(n_peer == tgt && busy === 1'b0 && ss_w === 1'b1) && t < 5000)
		begin
			@(negedge ref_clk);
			t++;
		end
		check("link_done", {8'h00, busy}, 9'h000);
	endtask
	// Watchers: timeout, clock high time, received characters at both ends.
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			errors++;
			wrap_up();
		end
		if (sck_o === 1'b1)
			hi_run++;
		else if (hi_run > 0)
		begin
			check("sck_high", 9'(hi_run), 9'(clk_div) + 9'h001);
			hi_run = 0;
		end
		if (!rst && rx_overrun !== 1'b0)
			check("rx_overrun", {8'h00, rx_overrun}, 9'h000);
		if (rx_valid === 1'b1 && rx_ready === 1'b1 && q_rx.size() > 0)
			check("rx_data", rx_data & mask, q_rx.pop_front());
	end
	always @(n_peer)
		if (n_peer > 0 && q_peer.size() > 0)
			check("peer_got", peer_got, q_peer.pop_front());
	// Two back-to-back characters per transaction, every length and order.
	initial
	begin
		void'($urandom(32'h0197_8f66));
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		repeat (2) @(negedge ref_clk);
		for (int c = 0; c < 4; c++)
		begin
			char9 = c[0];
			lsb_first = c[1];
			mask = char9 ? 9'h1ff : 9'h0ff;
			resp = 9'($urandom);
			clk_div = 8'h04 + 8'($urandom_range(3));
			send(9'($urandom), 0);
			send(9'($urandom), 1);
			wait_idle(2 * (c + 1));
			check("ss_rises", 9'(n_ss), 9'(c + 1));
			check("rx_held", {8'h00, rx_valid}, 9'h001);
			rx_ready = 1'b1;
			repeat (4) @(negedge ref_clk);
			check("rx_empty", {8'h00, rx_valid}, 9'h000);
			check("rx_left", 9'(q_rx.size()), 9'h000);
			rx_ready = 1'b0;
		end
		wrap_up();
	end
endmodule
